// ==== companion_map.svh ====
// Purpose: shared constants for the companion slave and its bus master
// Assumes: 200 MHz mclk_i, all times counted on it
// Notes: counts derive from times by expressions below
`ifndef COMPANION_MAP_SVH
`define COMPANION_MAP_SVH

`define CLK_NS       5
`define DEV_MEM      4'ha
`define DEV_COMP     4'hd
`define REG_TOP      5'h18
`define REG_WDOG     5'h0a
`define MEM_TOP      15'h7fff
`define WDOG_FLD     4:0
// supply dip filter, 15 us sits inside 10..25 us
`define DIP_NS       15000
`define DIP_CYC      (`DIP_NS / `CLK_NS)
// one millisecond time base
`define TICK_NS      1000000
`define TICK_CYC     (`TICK_NS / `CLK_NS)
// reset hold, 150 ms sits inside 100..200 ms
`define HOLD_MS      8'h96
`define WD_UNIT_MS   12'h064
// master scl at 1 MHz, four quarters per bit
`define SCL_NS       1000
`define QTR_CYC      (`SCL_NS / (4 * `CLK_NS))

`endif

// ==== companion_pkg.sv ====
// Purpose: state types for both ends
// Assumes: one-hot codes
// Notes: none
package companion_pkg;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_RX   = 6'h02,
      S_ACK  = 6'h04,
      S_TX   = 6'h08,
      S_MACK = 6'h10,
      S_NEXT = 6'h20
   } dev_state_e;
   typedef enum logic [3:0] {
      H_IDLE  = 4'h1,
      H_START = 4'h2,
      H_BYTE  = 4'h4,
      H_STOP  = 4'h8
   } host_state_e;
   typedef enum logic [5:0] {
      P_ADW = 6'h01,
      P_PHI = 6'h02,
      P_PLO = 6'h04,
      P_DAT = 6'h08,
      P_ADR = 6'h10,
      P_RD  = 6'h20
   } step_e;
endpackage

// ==== i2c_if.sv ====
// Purpose: two-wire bus between master and companion slave
// Assumes: open drain, enable high pulls the wire to the output level
// Notes: lines resolve here, pull-ups implied
`timescale 1ns/1ps
interface i2c_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;
   // wired-and of both drivers on sda, scl has the host as its only driver
   assign scl = !(m_scl_oe && !m_scl_o);
   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
   modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
   modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
                 output m_sda_o, output m_sda_oe);
endinterface

// ==== bus_master.sv ====
// Purpose: host end, one command per transaction
// Assumes: slave never stretches scl
// Notes: reads fetch one byte and end with nack then stop
`timescale 1ns/1ps
`include "companion_map.svh"
module bus_master (
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   i2c_if.host             bus,
   input  wire logic       cmd_valid_i,
   output logic            cmd_ready_o,
   input  wire logic       cmd_comp_i,
   input  wire logic [1:0] cmd_sel_i,
   input  wire logic       cmd_read_i,
   input  wire logic       cmd_setptr_i,
   input  wire logic [14:0] cmd_addr_i,
   input  wire logic [7:0] cmd_wdata_i,
   output logic [7:0]      rdata_o,
   output logic            done_o,
   output logic            nack_o
);
   companion_pkg::host_state_e state, next_state;
   companion_pkg::step_e       step, next_step;
   logic [1:0]  sda_sy;
   logic [5:0]  qcnt, next_qcnt;
   logic        qen;
   logic [1:0]  q, next_q;
   logic [3:0]  bitn, next_bitn;
   logic [7:0]  tx, next_tx, rx, next_rx, next_rdata;
   logic        scl_oe, next_scl_oe, sda_oe, next_sda_oe;
   logic        nackd, next_nackd, next_nack, next_done;
   logic        comp, rd, setp, next_comp, next_rd, next_setp;
   logic [1:0]  sel, next_sel;
   logic [14:0] addr, next_addr;
   logic [7:0]  wdata, next_wdata;

   // byte placed on the wire for each step
   function automatic logic [7:0] byte_for(input companion_pkg::step_e s);
      logic [3:0] ty;
      ty = comp ? `DEV_COMP : `DEV_MEM;
      case (s)
         companion_pkg::P_ADW: byte_for = {ty, 1'b0, sel, 1'b0};
         companion_pkg::P_PHI: byte_for = {1'b0, addr[14:8]};
         companion_pkg::P_PLO: byte_for = comp ? {3'h0, addr[4:0]} : addr[7:0];
         companion_pkg::P_DAT: byte_for = wdata;
         companion_pkg::P_ADR: byte_for = {ty, 1'b0, sel, 1'b1};
         default:              byte_for = 8'hff;
      endcase
   endfunction

   assign cmd_ready_o  = (state == companion_pkg::H_IDLE);
   assign bus.m_scl_o  = 1'b0;
   assign bus.m_sda_o  = 1'b0;
   assign bus.m_scl_oe = scl_oe;
   assign bus.m_sda_oe = sda_oe;
   assign qen = (qcnt == 6'(`QTR_CYC - 1));

   // quarter-bit divider, runs only inside a transaction
   always_comb begin
      next_qcnt = (qen || cmd_ready_o) ? 6'h00 : qcnt + 6'h01;
   end

   // sequencer, pins move on quarter enables
   always_comb begin
      next_state = state;  next_step = step;  next_q = q;
      next_bitn = bitn;    next_tx = tx;      next_rx = rx;
      next_scl_oe = scl_oe; next_sda_oe = sda_oe;
      next_nackd = nackd;  next_nack = nack_o; next_done = 1'b0;
      next_rdata = rdata_o;
      next_comp = comp; next_rd = rd; next_setp = setp;
      next_sel = sel; next_addr = addr; next_wdata = wdata;
      case (state)
         companion_pkg::H_IDLE: begin
            if (cmd_valid_i) begin
               next_comp = cmd_comp_i;  next_rd = cmd_read_i;
               next_setp = cmd_setptr_i; next_sel = cmd_sel_i;
               next_addr = cmd_addr_i;  next_wdata = cmd_wdata_i;
               next_nack = 1'b0;
               // a write always opens with its address
               next_step = (cmd_read_i && !cmd_setptr_i) ?
                           companion_pkg::P_ADR : companion_pkg::P_ADW;
               next_q = 2'h0;
               next_state = companion_pkg::H_START;
            end
         end
         companion_pkg::H_START: if (qen) begin
            next_q = q + 2'h1;
            case (q)
               2'h0: begin next_sda_oe = 1'b0; next_scl_oe = 1'b1; end
               2'h1: next_scl_oe = 1'b0;
               2'h2: next_sda_oe = 1'b1;
               default: begin
                  next_scl_oe = 1'b1;
                  next_bitn = 4'h0;
                  next_tx = byte_for(step);
                  next_state = companion_pkg::H_BYTE;
               end
            endcase
         end
         companion_pkg::H_BYTE: if (qen) begin
            next_q = q + 2'h1;
            case (q)
               2'h0: next_sda_oe = (bitn < 4'h8) && (step != companion_pkg::P_RD) && !tx[7];
               2'h1: next_scl_oe = 1'b0;
               2'h2: begin
                  if (bitn < 4'h8) next_rx = {rx[6:0], sda_sy[1]};
                  else next_nackd = sda_sy[1];
               end
               default: begin
                  next_scl_oe = 1'b1;
                  next_bitn = bitn + 4'h1;
                  next_tx = {tx[6:0], 1'b0};
                  if (bitn == 4'h8) begin
                     next_bitn = 4'h0;
                     next_state = companion_pkg::H_BYTE;
                     if (step == companion_pkg::P_RD) begin
                        next_rdata = rx;
                        next_state = companion_pkg::H_STOP;
                     end else if (nackd) begin
                        next_nack = 1'b1;
                        next_state = companion_pkg::H_STOP;
                     end else begin
                        case (step)
                           companion_pkg::P_ADW: next_step = comp ?
                              companion_pkg::P_PLO : companion_pkg::P_PHI;
                           companion_pkg::P_PHI: next_step = companion_pkg::P_PLO;
                           companion_pkg::P_PLO: next_step = rd ?
                              companion_pkg::P_ADR : companion_pkg::P_DAT;
                           companion_pkg::P_ADR: next_step = companion_pkg::P_RD;
                           default: next_state = companion_pkg::H_STOP;
                        endcase
                        // pointer loaded, restart as a read
                        if (step == companion_pkg::P_PLO && rd)
                           next_state = companion_pkg::H_START;
                        next_tx = byte_for(next_step);
                     end
                  end
               end
            endcase
         end
         companion_pkg::H_STOP: if (qen) begin
            next_q = q + 2'h1;
            case (q)
               2'h0: next_sda_oe = 1'b1;
               2'h1: next_scl_oe = 1'b0;
               2'h2: next_sda_oe = 1'b0;
               default: begin
                  next_done = 1'b1;
                  next_state = companion_pkg::H_IDLE;
               end
            endcase
         end
         default: next_state = companion_pkg::H_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      sda_sy <= {sda_sy[0], bus.sda};
      if (rst_i) begin
         state <= companion_pkg::H_IDLE; step <= companion_pkg::P_ADW;
         qcnt <= 6'h00; q <= 2'h0; bitn <= 4'h0; tx <= 8'h00; rx <= 8'h00;
         scl_oe <= 1'b0; sda_oe <= 1'b0; nackd <= 1'b0; nack_o <= 1'b0;
         done_o <= 1'b0; rdata_o <= 8'h00; comp <= 1'b0; rd <= 1'b0;
         setp <= 1'b0; sel <= 2'h0; addr <= 15'h0000; wdata <= 8'h00;
         sda_sy <= 2'h3;
      end else begin
         state <= next_state; step <= next_step; qcnt <= next_qcnt;
         q <= next_q; bitn <= next_bitn; tx <= next_tx; rx <= next_rx;
         scl_oe <= next_scl_oe; sda_oe <= next_sda_oe; nackd <= next_nackd;
         nack_o <= next_nack; done_o <= next_done; rdata_o <= next_rdata;
         comp <= next_comp; rd <= next_rd; setp <= next_setp;
         sel <= next_sel; addr <= next_addr; wdata <= next_wdata;
      end
   end
endmodule

// ==== companion_slave.sv ====
// Purpose: device end, memory and register slave plus supervisor
// Assumes: supply_ok_i from an analog comparator, asynchronous
// Notes: register contents are plain storage, period field at 0ah
`timescale 1ns/1ps
`include "companion_map.svh"
module companion_slave #(
   parameter int TICK_CYC = `TICK_CYC
) (
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   i2c_if.dev              bus,
   input  wire logic [1:0] dev_sel_i,
   input  wire logic       supply_ok_i,
   input  wire logic       wdog_kick_i,
   output logic            rst_n_o
);
   companion_pkg::dev_state_e state, next_state;
   logic [1:0]  scl_sy, sda_sy, ok_sy;
   logic        scl_q, sda_q;
   logic        scl_rise, scl_fall, start_c, stop_c;
   logic [3:0]  bitcnt, next_bitcnt;
   logic [7:0]  sh, next_sh;
   logic [1:0]  phase, next_phase;
   logic        is_reg, next_is_reg, is_rd, next_is_rd;
   logic        oe, next_oe;
   logic [14:0] mem_ptr, next_mem_ptr;
   logic [4:0]  reg_ptr, next_reg_ptr;
   logic        mem_we, reg_we;
   logic [7:0]  rd_byte;
   logic [7:0]  mem [0:32767];
   logic [7:0]  regs [0:24];
   logic [11:0] dip_cnt, next_dip_cnt;
   logic [17:0] tick_cnt, next_tick_cnt;
   logic        tick;
   logic [7:0]  hold_cnt, next_hold_cnt;
   logic [11:0] wd_cnt, next_wd_cnt, wd_limit;
   logic        rst_act, next_rst_act;

   assign bus.s_sda_o  = 1'b0;
   assign bus.s_sda_oe = oe;
   assign rst_n_o      = ~rst_act;

   // edges seen on the second synchroniser stage only
   assign scl_rise = scl_sy[1] & ~scl_q;
   assign scl_fall = ~scl_sy[1] & scl_q;
   assign start_c  = scl_sy[1] & scl_q & sda_q & ~sda_sy[1];
   assign stop_c   = scl_sy[1] & scl_q & ~sda_q & sda_sy[1];

   // byte served next, from whichever pointer the address chose
   assign rd_byte = is_reg ? regs[reg_ptr] : mem[mem_ptr];

   // bus protocol engine
   always_comb begin
      next_state = state;   next_bitcnt = bitcnt; next_sh = sh;
      next_phase = phase;   next_is_reg = is_reg; next_is_rd = is_rd;
      next_oe = oe;         next_mem_ptr = mem_ptr; next_reg_ptr = reg_ptr;
      mem_we = 1'b0;        reg_we = 1'b0;
      if (start_c) begin
         // restart drops any partial byte, nothing gets stored
         next_state = companion_pkg::S_RX;
         next_bitcnt = 4'h0;
         next_phase = 2'h0;
         next_oe = 1'b0;
      end else if (stop_c) begin
         next_state = companion_pkg::S_IDLE;
         next_oe = 1'b0;
      end else begin
         case (state)
            companion_pkg::S_IDLE: next_oe = 1'b0;
            companion_pkg::S_RX: begin
               if (scl_rise && bitcnt < 4'h8) begin
                  next_sh = {sh[6:0], sda_sy[1]};
                  next_bitcnt = bitcnt + 4'h1;
               end else if (scl_fall && bitcnt == 4'h8) begin
                  next_oe = 1'b1;
                  next_state = companion_pkg::S_ACK;
                  case (phase)
                     2'h0: begin
                        if ((sh[7:4] == `DEV_MEM || sh[7:4] == `DEV_COMP)
                            && sh[2:1] == dev_sel_i) begin
                           next_is_reg = (sh[7:4] == `DEV_COMP);
                           next_is_rd = sh[0];
                           next_phase = sh[0] ? 2'h3 :
                                        ((sh[7:4] == `DEV_COMP) ? 2'h2 : 2'h1);
                        end else begin
                           next_oe = 1'b0;
                           next_state = companion_pkg::S_IDLE;
                        end
                     end
                     2'h1: begin
                        next_mem_ptr = {sh[6:0], mem_ptr[7:0]};
                        next_phase = 2'h2;
                     end
                     2'h2: begin
                        next_phase = 2'h3;
                        if (!is_reg) begin
                           next_mem_ptr = {mem_ptr[14:8], sh};
                        end else if (sh > {3'h0, `REG_TOP}) begin
                           // out of range: no ack, transaction dropped
                           next_oe = 1'b0;
                           next_state = companion_pkg::S_IDLE;
                        end else begin
                           next_reg_ptr = sh[4:0];
                        end
                     end
                     default: begin
                        // store on the 8th bit, step before the ack
                        if (is_reg) begin
                           reg_we = 1'b1;
                           next_reg_ptr = (reg_ptr == `REG_TOP) ? 5'h00 :
                                          reg_ptr + 5'h01;
                        end else begin
                           mem_we = 1'b1;
                           next_mem_ptr = (mem_ptr == `MEM_TOP) ? 15'h0000 :
                                          mem_ptr + 15'h0001;
                        end
                     end
                  endcase
               end
            end
            companion_pkg::S_ACK: if (scl_fall) begin
               next_bitcnt = 4'h0;
               next_oe = 1'b0;
               next_state = companion_pkg::S_RX;
               if (is_rd) begin
                  next_state = companion_pkg::S_NEXT;
               end
            end
            companion_pkg::S_NEXT: begin
               // load and drive first bit at once, and count the pointer on the same edge
               next_oe = ~rd_byte[7];
               next_sh = {rd_byte[6:0], 1'b0};
               next_bitcnt = 4'h1;
               next_state = companion_pkg::S_TX;
               if (is_reg) begin
                  next_reg_ptr = (reg_ptr == `REG_TOP) ? 5'h00 :
                                 reg_ptr + 5'h01;
               end else begin
                  next_mem_ptr = (mem_ptr == `MEM_TOP) ? 15'h0000 :
                                 mem_ptr + 15'h0001;
               end
            end
            companion_pkg::S_TX: if (scl_fall) begin
               if (bitcnt == 4'h8) begin
                  next_oe = 1'b0;
                  next_state = companion_pkg::S_MACK;
               end else begin
                  next_oe = ~sh[7];
                  next_sh = {sh[6:0], 1'b0};
                  next_bitcnt = bitcnt + 4'h1;
               end
            end
            companion_pkg::S_MACK: begin
               // master ack means one more byte, nack ends the read
               if (scl_rise) begin
                  next_state = sda_sy[1] ? companion_pkg::S_IDLE : companion_pkg::S_ACK;
               end
            end
            default: next_state = companion_pkg::S_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      scl_sy <= {scl_sy[0], bus.scl};
      sda_sy <= {sda_sy[0], bus.sda};
      scl_q <= scl_sy[1];
      sda_q <= sda_sy[1];
      if (rst_i) begin
         state <= companion_pkg::S_IDLE;
         scl_sy <= 2'h3; sda_sy <= 2'h3; scl_q <= 1'b1; sda_q <= 1'b1;
         bitcnt <= 4'h0; sh <= 8'h00; phase <= 2'h0;
         is_reg <= 1'b0; is_rd <= 1'b0; oe <= 1'b0;
         mem_ptr <= 15'h0000; reg_ptr <= 5'h00;
      end else begin
         state <= next_state; bitcnt <= next_bitcnt; sh <= next_sh;
         phase <= next_phase; is_reg <= next_is_reg; is_rd <= next_is_rd;
         oe <= next_oe; mem_ptr <= next_mem_ptr; reg_ptr <= next_reg_ptr;
      end
   end

   // memory array keeps contents across reset, no clear needed
   always_ff @(posedge mclk_i) begin
      if (mem_we) begin
         mem[mem_ptr] <= sh;
      end
   end

   // register bank, cleared so the watchdog starts disabled
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 25; i++) regs[i] <= 8'h00;
      end else if (reg_we) begin
         regs[reg_ptr] <= sh;
      end
   end

   // supervisor: dip filter, reset hold, watchdog
   assign tick = (tick_cnt == 18'(TICK_CYC - 1));
   assign wd_limit = 12'(regs[`REG_WDOG][`WDOG_FLD]) * `WD_UNIT_MS;
   always_comb begin
      next_tick_cnt = tick ? 18'h00000 : tick_cnt + 18'h00001;
      next_dip_cnt = dip_cnt;
      next_hold_cnt = hold_cnt;
      next_wd_cnt = wd_cnt;
      next_rst_act = rst_act;
      if (!ok_sy[1]) begin
         // short dips are filtered out, long ones assert reset
         if (dip_cnt == 12'(`DIP_CYC - 1)) begin
            next_rst_act = 1'b1;
         end else begin
            next_dip_cnt = dip_cnt + 12'h001;
         end
         next_hold_cnt = 8'h00;
      end else begin
         next_dip_cnt = 12'h000;
      end
      if (rst_act && ok_sy[1] && tick) begin
         if (hold_cnt == `HOLD_MS - 8'h01) begin
            next_rst_act = 1'b0;
            next_hold_cnt = 8'h00;
         end else begin
            next_hold_cnt = hold_cnt + 8'h01;
         end
      end
      // watchdog idles while in reset or when its period is zero
      if (rst_act || wd_limit == 12'h000 || wdog_kick_i) begin
         next_wd_cnt = 12'h000;
      end else if (tick) begin
         if (wd_cnt == wd_limit - 12'h001) begin
            next_rst_act = 1'b1;
            next_hold_cnt = 8'h00;
            next_wd_cnt = 12'h000;
         end else begin
            next_wd_cnt = wd_cnt + 12'h001;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      ok_sy <= {ok_sy[0], supply_ok_i};
      if (rst_i) begin
         ok_sy <= 2'h0; tick_cnt <= 18'h00000; dip_cnt <= 12'h000;
         hold_cnt <= 8'h00; wd_cnt <= 12'h000; rst_act <= 1'b1;
      end else begin
         tick_cnt <= next_tick_cnt; dip_cnt <= next_dip_cnt;
         hold_cnt <= next_hold_cnt; wd_cnt <= next_wd_cnt;
         rst_act <= next_rst_act;
      end
   end
endmodule

// ==== companion_properties.sv ====
// Purpose: wire checks on the two-wire bus between the two ends
// Assumes: one 200 MHz domain, device samples scl through a synchroniser
// Notes: device moves sda a few cycles after scl falls, never while high
`timescale 1ns/1ps
module companion_properties (
   input  wire logic mclk_i,
   input  wire logic rst_i,
   input  wire logic m_scl_oe,
   input  wire logic m_sda_oe,
   input  wire logic s_sda_o,
   input  wire logic s_sda_oe,
   input  wire logic scl,
   input  wire logic sda
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   // device pulls low only, and never fights the host while scl is high
   property p_dev_pulls_low;
      s_sda_oe && scl |-> !s_sda_o && !m_sda_oe;
   endproperty
   a_dev_pulls_low: assert property (p_dev_pulls_low)
      else $error("device drives sda high");
   // a device change with scl high would look like start or stop
   property p_dev_quiet_high;
      scl && $past(scl) |-> $stable(s_sda_oe);
   endproperty
   a_dev_quiet_high: assert property (p_dev_quiet_high)
      else $error("device moved sda while scl high");
   property p_dev_take_late;
      $rose(s_sda_oe) |-> !scl && !$past(scl, 2);
   endproperty
   a_dev_take_late: assert property (p_dev_take_late)
      else $error("device took sda too soon after scl fall");
   property p_dev_release_late;
      $fell(s_sda_oe) |-> !scl && !$past(scl, 2);
   endproperty
   a_dev_release_late: assert property (p_dev_release_late)
      else $error("device released sda too soon after scl fall");
   // only the host makes a start
   property p_start_by_host;
      $fell(sda) && scl && $past(scl) |-> m_sda_oe;
   endproperty
   a_start_by_host: assert property (p_start_by_host)
      else $error("start not made by host");
   property p_scl_high_min;
      $rose(scl) |-> scl [*8];
   endproperty
   a_scl_high_min: assert property (p_scl_high_min)
      else $error("scl high phase too short");
   property p_scl_low_min;
      $fell(scl) |-> !scl [*8];
   endproperty
   a_scl_low_min: assert property (p_scl_low_min)
      else $error("scl low phase too short");
   property p_idle_after_reset;
      $fell(rst_i) |-> !s_sda_oe && !m_sda_oe && !m_scl_oe;
   endproperty
   a_idle_after_reset: assert property (p_idle_after_reset)
      else $error("bus not released after reset");
endmodule

// ==== i2c_memory_companion_slave_tb_top.sv ====
// Purpose: drives both ends through the host command port
// Assumes: TICK_CYC of 20, so a 150 tick hold is 3000 cycles
// Notes: one byte per command; expected values worked out here
`timescale 1ns/1ps
module i2c_memory_companion_slave_tb_top;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cmd_valid_i = 1'b0;
   logic        cmd_ready_o;
   logic        cmd_comp_i = 1'b0;
   logic [1:0]  cmd_sel_i = 2'h2;
   logic        cmd_read_i = 1'b0;
   logic        cmd_setptr_i = 1'b0;
   logic [14:0] cmd_addr_i = 15'h0000;
   logic [7:0]  cmd_wdata_i = 8'h00;
   logic [7:0]  rdata_o;
   logic        done_o;
   logic        nack_o;
   logic        supply_ok_i = 1'b1;
   logic        wdog_kick_i = 1'b0;
   logic        rst_n_o;
   int          err_total = 0;
   int          comparisons = 0;

   i2c_if bus ();
   always #2.5 mclk_i = !mclk_i;
   bus_master i_bus_master (.mclk_i(mclk_i), .rst_i(rst_i), .bus(bus),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_comp_i(cmd_comp_i),
      .cmd_sel_i(cmd_sel_i), .cmd_read_i(cmd_read_i), .cmd_setptr_i(cmd_setptr_i),
      .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .rdata_o(rdata_o),
      .done_o(done_o), .nack_o(nack_o));
   companion_slave #(.TICK_CYC(20)) i_companion_slave (.mclk_i(mclk_i), .rst_i(rst_i),
      .bus(bus), .dev_sel_i(2'h2), .supply_ok_i(supply_ok_i), .wdog_kick_i(wdog_kick_i),
      .rst_n_o(rst_n_o));
   companion_properties i_companion_properties (.mclk_i(mclk_i), .rst_i(rst_i),
      .m_scl_oe(bus.m_scl_oe), .m_sda_oe(bus.m_sda_oe), .s_sda_o(bus.s_sda_o),
      .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));

   task automatic end_of_test;
      if (err_total == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // inputs always change 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one host command; ready is idle, so valid is taken at the first edge
   task automatic xfer(input logic comp, input logic [1:0] sel, input logic rd,
                       input logic setp, input logic [14:0] addr, input logic [7:0] wd);
      int n;
      n = 0;
      {cmd_comp_i, cmd_sel_i, cmd_read_i, cmd_setptr_i, cmd_addr_i, cmd_wdata_i} =
         {comp, sel, rd, setp, addr, wd};
      chk("ready idle", cmd_ready_o, 8'h01);
      cmd_valid_i = 1'b1;
      tick(1);
      cmd_valid_i = 1'b0;
      chk("ready busy", cmd_ready_o, 8'h00);
      while (done_o !== 1'b1 && n < 20000) begin
         tick(1);
         n++;
      end
      chk("done", done_o, 8'h01);
   endtask
   task automatic wr(input logic comp, input logic [1:0] sel, input logic [14:0] addr,
                     input logic [7:0] wd, input logic exp_nack);
      xfer(comp, sel, 1'b0, 1'b1, addr, wd);
      chk("write nack", nack_o, exp_nack);
   endtask
   task automatic rd_chk(input string what, input logic comp, input logic setp,
                         input logic [14:0] addr, input logic [7:0] exp);
      xfer(comp, 2'h2, 1'b1, setp, addr, 8'h00);
      chk(what, rdata_o, exp);
      chk("read nack", nack_o, 8'h00);
   endtask

   // main sequence: supervisor, then bus traffic, then watchdog
   initial begin
      tick(8);
      rst_i = 1'b0;
      tick(2900);
      chk("power-up hold", rst_n_o, 8'h00);
      tick(200);
      chk("power-up end", rst_n_o, 8'h01);
      supply_ok_i = 1'b0;
      tick(1000);
      supply_ok_i = 1'b1;
      tick(100);
      chk("short dip", rst_n_o, 8'h01);
      supply_ok_i = 1'b0;
      tick(1900);
      chk("dip filtered", rst_n_o, 8'h01);
      tick(3050);
      chk("dip reset", rst_n_o, 8'h00);
      supply_ok_i = 1'b1;
      tick(3100);
      chk("dip recovery", rst_n_o, 8'h01);
      wr(1'b0, 2'h2, 15'h0000, 8'h3c, 1'b0);
      wr(1'b0, 2'h2, 15'h7fff, 8'ha5, 1'b0);
      rd_chk("mem 7fff", 1'b0, 1'b1, 15'h7fff, 8'ha5);
      wr(1'b1, 2'h2, 15'h0005, 8'h77, 1'b0);
      rd_chk("reg 05", 1'b1, 1'b1, 15'h0005, 8'h77);
      rd_chk("reg 06", 1'b1, 1'b0, 15'h0000, 8'h00);
      rd_chk("mem resume", 1'b0, 1'b0, 15'h0000, 8'h3c);
      wr(1'b1, 2'h2, 15'h0019, 8'h11, 1'b1);
      wr(1'b0, 2'h1, 15'h0000, 8'hff, 1'b1);
      rd_chk("mem kept", 1'b0, 1'b1, 15'h0000, 8'h3c);
      wr(1'b1, 2'h2, 15'h000a, 8'h01, 1'b0);
      repeat (2) begin
         tick(1500);
         chk("kicked", rst_n_o, 8'h01);
         wdog_kick_i = 1'b1;
         tick(1);
         wdog_kick_i = 1'b0;
      end
      tick(1900);
      chk("before timeout", rst_n_o, 8'h01);
      tick(200);
      chk("timeout", rst_n_o, 8'h00);
      tick(2800);
      chk("watchdog pulse", rst_n_o, 8'h00);
      tick(200);
      chk("watchdog pulse end", rst_n_o, 8'h01);
      end_of_test();
   end

   // hang guard, a tenth past the expected run, kept under 100k cycles
   initial begin
      #490000;
      err_total++;
      end_of_test();
   end
endmodule
